// ### hw/scfe_cfg.svh
`ifndef SCFE_CFG_SVH
`define SCFE_CFG_SVH
// command codes on {cs_n, ras_n, cas_n, we_n}
`define SCFE_CMD_ACT 4'h3
`define SCFE_CMD_RD 4'h5
`define SCFE_CMD_WR 4'h4
`define SCFE_CMD_PRE 4'h2
`define SCFE_CMD_REF 4'h1
// address bit that carries the auto close flag
`define SCFE_ADDR_AP 10
// added latency selector codes
`define SCFE_AL_CL1 2'h1
`define SCFE_AL_CL2 2'h2
// default cas and cas write latencies, in link clocks
`define SCFE_CL_DEF 11
`define SCFE_CWL_DEF 8
// byte-pair cycles of a burst of eight and of four
`define SCFE_PAIRS_BL8 3'h4
`define SCFE_PAIRS_BL4 3'h2
// strobe levels at the rising and falling crossing
`define SCFE_DQS_LEVELS 2'h2
// reset values
`define SCFE_BANKS_IDLE 8'h00
`endif

// ### hw/scfe_pkg.sv
package scfe_pkg;
  // power state seen at the link
  typedef enum logic [1:0] {
    PM_RUN,
    PM_SUSPEND,
    PM_POWER_DOWN,
    PM_SELF_REFRESH
  } scfe_pm_t;
  // one byte at the rising crossing, one at the falling crossing
  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
  } scfe_pair_t;
  // strobe level at each crossing
  typedef struct packed {
    logic rise;
    logic fall;
  } scfe_dqs_t;
  // clock enable, command and address as sampled at the rising crossing
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [14:0] addr;
  } scfe_cmd_t;
  // state of the link-side logic, apart from the reset and mode synchronisers
  typedef struct packed {
    logic cke_q;
    scfe_pm_t pm;
    logic [7:0] bank_open;
    logic pend;
    logic dir_wr;
    logic [5:0] lat;
    logic burst;
    logic [2:0] beat;
    logic [2:0] pairs;
    logic [2:0] col;
    logic il;
    logic ap;
    logic [2:0] ap_bank;
    logic [63:0] rd_word;
    scfe_pair_t dq;
    logic dq_oe;
    scfe_dqs_t dqs;
    logic [63:0] wr_word;
    logic wr_valid;
    logic strobe_err;
    logic underrun;
  } scfe_link_t;
endpackage

// ### hw/scfe_front_end.sv
// How it works
// - commands taken only at rising clock crossing
// - read data changes on both clock crossings
// - strobe pair travels with data both ways
// - clock enable low freezes outputs and burst
// - self refresh entry only with banks idle
// - eight banks opened and closed independently
// - bursts of four or eight, sequential/interleaved
// - added latency zero, cas minus one, minus two
// - chip select high masks every command
// - address bit ten requests auto close
`include "scfe_cfg.svh"

// dual-clock fifo, gray pointers cross between the two clocks
module scfe_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 16
) (
  // fill side
  input wire logic wclk_i,
  input wire logic wrst_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic wvalid_i,
  output logic wready_o,
  // drain side
  input wire logic rclk_i,
  input wire logic rrst_i,
  output logic [W-1:0] rdata_o,
  output logic rvalid_o,
  input wire logic rready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];  // storage, written on the fill clock
  logic [AW:0] wbin_q, wbin_d, wgray_q;  // fill pointer, binary and gray
  logic [AW:0] rbin_q, rbin_d, rgray_q;  // drain pointer
  logic [AW:0] rg_meta_q, rg_sync_q;  // drain pointer seen by fill side
  logic [AW:0] wg_meta_q, wg_sync_q;  // fill pointer seen by drain side
  logic [AW:0] wgray_d, rgray_d;

  // full when the gray pointers differ only in the top two bits
  assign wready_o = (wgray_q != {~rg_sync_q[AW:AW-1], rg_sync_q[AW-2:0]});
  assign rvalid_o = (rgray_q != wg_sync_q);
  assign rdata_o = mem[rbin_q[AW-1:0]];

  // next pointers
  always_comb begin
    wbin_d = wbin_q + {{AW{1'b0}}, (wvalid_i & wready_o)};
    rbin_d = rbin_q + {{AW{1'b0}}, (rready_i & rvalid_o)};
    wgray_d = wbin_d ^ (wbin_d >> 1);
    rgray_d = rbin_d ^ (rbin_d >> 1);
  end

  // fill clock: pointer, storage and the drain pointer synchroniser
  always_ff @(posedge wclk_i) begin
    if (wvalid_i & wready_o) begin
      mem[wbin_q[AW-1:0]] <= wdata_i;
    end
    if (wrst_i) begin
      wbin_q <= '0;
      wgray_q <= '0;
      rg_meta_q <= '0;
      rg_sync_q <= '0;
    end else begin
      wbin_q <= wbin_d;
      wgray_q <= wgray_d;
      rg_meta_q <= rgray_q;
      rg_sync_q <= rg_meta_q;
    end
  end

  // drain clock: pointer and the fill pointer synchroniser
  always_ff @(posedge rclk_i) begin
    if (rrst_i) begin
      rbin_q <= '0;
      rgray_q <= '0;
      wg_meta_q <= '0;
      wg_sync_q <= '0;
    end else begin
      rbin_q <= rbin_d;
      rgray_q <= rgray_d;
      wg_meta_q <= wgray_q;
      wg_sync_q <= wg_meta_q;
    end
  end
endmodule

module scfe_front_end #(
  parameter int CL = `SCFE_CL_DEF,
  parameter int CWL = `SCFE_CWL_DEF,
  parameter int DEPTH = 16
) (
  // core clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // true clock of the link pair
  input wire logic ck_i,
  // host pins, link clock domain
  input wire scfe_pkg::scfe_cmd_t cmd_i,
  input wire scfe_pkg::scfe_pair_t dq_i,
  input wire scfe_pkg::scfe_dqs_t dqs_i,
  output scfe_pkg::scfe_pair_t dq_o,
  output logic dq_oe_o,
  output scfe_pkg::scfe_dqs_t dqs_o,
  output scfe_pkg::scfe_dqs_t dqs_n_o,
  output logic dqs_oe_o,
  // mode settings, core domain, quasi static
  input wire logic bl4_i,
  input wire logic interleave_i,
  input wire logic [1:0] al_sel_i,
  // read data fill, core domain
  input wire logic [63:0] fill_data_i,
  input wire logic fill_valid_i,
  output logic fill_ready_o,
  // write data and link events, link clock domain
  output logic [63:0] wr_word_o,
  output logic wr_valid_o,
  output logic strobe_err_o,
  output logic underrun_o,
  // status, core domain
  output logic [7:0] bank_open_o,
  output logic suspended_o,
  output logic power_down_o,
  output logic self_refresh_o
);
  import scfe_pkg::*;

  scfe_link_t ls_q, ls_d;  // link-side state
  logic rst_meta_q, link_rst;  // core reset brought to the link clock
  logic [3:0] mode_meta_q, mode_sync_q;  // mode bits on the link clock
  logic [10:0] st_meta_q, st_sync_q;  // status on the core clock
  logic [63:0] fifo_data;  // head of the read fifo
  logic fifo_valid;
  logic pop;  // drain one word into a read burst
  logic [3:0] cmd_code;
  logic run;  // internal clock running this edge
  logic live;  // command accepted this edge
  logic acc_rw;  // read or write accepted
  logic [5:0] al;  // added_latency in link clocks
  logic [5:0] rl, wl;
  logic idle;

  // beat index to column within the eight-byte prefetch
  function automatic logic [2:0] beat_col(input logic [2:0] c,
                                          input logic il,
                                          input logic [2:0] k);
    beat_col = il ? (c ^ k) : {c[2] ^ k[2], 2'(c[1:0] + k[1:0])};
  endfunction

  // pair of bytes for one link cycle of a read burst
  function automatic scfe_pair_t pick(input logic [63:0] w,
                                      input logic [2:0] c,
                                      input logic il,
                                      input logic [2:0] p);
    logic [2:0] k;
    k = {p[1:0], 1'b0};
    pick.rise = w[8*beat_col(c, il, k) +: 8];
    pick.fall = w[8*beat_col(c, il, k | 3'h1) +: 8];
  endfunction

  // read words cross from the core clock to the link clock here
  scfe_fifo #(.W(64), .DEPTH(DEPTH)) u_fifo (
    .wclk_i(clk_i),
    .wrst_i(reset_i),
    .wdata_i(fill_data_i),
    .wvalid_i(fill_valid_i),
    .wready_o(fill_ready_o),
    .rclk_i(ck_i),
    .rrst_i(link_rst),
    .rdata_o(fifo_data),
    .rvalid_o(fifo_valid),
    .rready_i(pop)
  );

  // reset and mode bits into the link domain; the host clock must run
  // for a few cycles while reset is held
  always_ff @(posedge ck_i) begin
    rst_meta_q <= reset_i;
    link_rst <= rst_meta_q;
    if (link_rst) begin
      mode_meta_q <= 4'h0;
      mode_sync_q <= 4'h0;
    end else begin
      mode_meta_q <= {bl4_i, interleave_i, al_sel_i};
      mode_sync_q <= mode_meta_q;
    end
  end

  // latencies; cas latency is taken as at least three
  always_comb begin
    case (mode_sync_q[1:0])
      `SCFE_AL_CL1: al = 6'(CL - 1);
      `SCFE_AL_CL2: al = 6'(CL - 2);
      default: al = 6'h0;
    endcase
    rl = 6'(al + 6'(CL));
    wl = 6'(al + 6'(CWL));
  end

  // command decode, chip select is part of the code
  assign cmd_code = {cmd_i.cs_n, cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
  assign run = ls_q.cke_q;
  assign live = run & cmd_i.cke;
  assign idle = (ls_q.bank_open == `SCFE_BANKS_IDLE) & ~ls_q.pend &
                ~ls_q.burst;
  assign acc_rw = live & ~ls_q.pend & ~ls_q.burst &
                  ls_q.bank_open[cmd_i.ba] &
                  ((cmd_code == `SCFE_CMD_RD) | (cmd_code == `SCFE_CMD_WR));

  // link state: latency, bursts, banks and power state
  always_comb begin
    ls_d = ls_q;
    pop = 1'b0;
    ls_d.cke_q = cmd_i.cke;
    ls_d.wr_valid = 1'b0;
    ls_d.strobe_err = 1'b0;
    ls_d.underrun = 1'b0;
    if (run) begin
      // latency countdown, then the first pair of the burst
      if (ls_q.pend) begin
        if (ls_q.lat > 6'h1) begin
          ls_d.lat = ls_q.lat - 6'h1;
        end else begin
          ls_d.pend = 1'b0;
          ls_d.burst = 1'b1;
          ls_d.beat = 3'h1;
          if (ls_q.dir_wr) begin
            // host strobe must toggle with its data
            ls_d.strobe_err = (dqs_i != `SCFE_DQS_LEVELS);
            ls_d.wr_word[8*beat_col(ls_q.col, ls_q.il, 3'h0) +: 8] =
              dq_i.rise;
            ls_d.wr_word[8*beat_col(ls_q.col, ls_q.il, 3'h1) +: 8] =
              dq_i.fall;
          end else begin
            // an empty fifo sends zeros rather than stalling the host
            pop = fifo_valid;
            ls_d.underrun = ~fifo_valid;
            ls_d.rd_word = fifo_valid ? fifo_data : 64'h0;
            ls_d.dq = pick(ls_d.rd_word, ls_q.col, ls_q.il, 3'h0);
            ls_d.dq_oe = 1'b1;
            ls_d.dqs = `SCFE_DQS_LEVELS;
          end
        end
      end
      // remaining pairs of a running burst
      if (ls_q.burst) begin
        if (ls_q.beat == ls_q.pairs) begin
          ls_d.burst = 1'b0;
          ls_d.dq_oe = 1'b0;
          ls_d.wr_valid = ls_q.dir_wr;
          if (ls_q.ap) begin
            ls_d.bank_open[ls_q.ap_bank] = 1'b0;
          end
        end else begin
          ls_d.beat = ls_q.beat + 3'h1;
          if (ls_q.dir_wr) begin
            ls_d.strobe_err = (dqs_i != `SCFE_DQS_LEVELS);
            ls_d.wr_word[8*beat_col(ls_q.col, ls_q.il,
                                    {ls_q.beat[1:0], 1'b0}) +: 8] = dq_i.rise;
            ls_d.wr_word[8*beat_col(ls_q.col, ls_q.il,
                                    {ls_q.beat[1:0], 1'b1}) +: 8] = dq_i.fall;
          end else begin
            ls_d.dq = pick(ls_q.rd_word, ls_q.col, ls_q.il, ls_q.beat);
          end
        end
      end
      if (!cmd_i.cke) begin
        // clock enable falls: pick the power state
        if (idle && cmd_code == `SCFE_CMD_REF) begin
          ls_d.pm = PM_SELF_REFRESH;
        end else if (idle) begin
          ls_d.pm = PM_POWER_DOWN;
        end else begin
          ls_d.pm = PM_SUSPEND;
        end
      end else begin
        // deselect and unknown codes fall to default and do nothing
        case (cmd_code)
          `SCFE_CMD_ACT: ls_d.bank_open[cmd_i.ba] = 1'b1;
          `SCFE_CMD_PRE: begin
            if (cmd_i.addr[`SCFE_ADDR_AP]) begin
              ls_d.bank_open = `SCFE_BANKS_IDLE;
            end else begin
              ls_d.bank_open[cmd_i.ba] = 1'b0;
            end
          end
          default: ls_d.pend = ls_d.pend;
        endcase
        // one access in flight; later ones are dropped until it ends
        if (acc_rw) begin
          ls_d.pend = 1'b1;
          ls_d.dir_wr = (cmd_code == `SCFE_CMD_WR);
          ls_d.lat = (cmd_code == `SCFE_CMD_WR) ? wl : rl;
          ls_d.col = cmd_i.addr[2:0];
          ls_d.il = mode_sync_q[2];
          ls_d.pairs = mode_sync_q[3] ? `SCFE_PAIRS_BL4 :
                       `SCFE_PAIRS_BL8;
          ls_d.ap = cmd_i.addr[`SCFE_ADDR_AP];
          ls_d.ap_bank = cmd_i.ba;
        end
      end
    end else begin
      // internal clock stopped: everything holds, exit on clock enable
      if (cmd_i.cke) begin
        ls_d.pm = PM_RUN;
      end
    end
    ls_d.dqs = ls_d.dq_oe ? scfe_dqs_t'(`SCFE_DQS_LEVELS) : scfe_dqs_t'(2'h0);
  end

  // link state register, taken only at the rising crossing
  always_ff @(posedge ck_i) begin
    if (link_rst) begin
      ls_q <= '0;
      ls_q.pm <= PM_RUN;
      ls_q.pairs <= `SCFE_PAIRS_BL8;
    end else begin
      ls_q <= ls_d;
    end
  end

  // status levels back to the core clock, each bit independent
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_meta_q <= 11'h0;
      st_sync_q <= 11'h0;
    end else begin
      st_meta_q <= {ls_q.bank_open, ls_q.pm == PM_SUSPEND,
                    ls_q.pm == PM_POWER_DOWN, ls_q.pm == PM_SELF_REFRESH};
      st_sync_q <= st_meta_q;
    end
  end

  assign dq_o = ls_q.dq;
  assign dq_oe_o = ls_q.dq_oe;
  assign dqs_o = ls_q.dqs;
  assign dqs_n_o = ~ls_q.dqs;
  assign dqs_oe_o = ls_q.dq_oe;
  assign wr_word_o = ls_q.wr_word;
  assign wr_valid_o = ls_q.wr_valid;
  assign strobe_err_o = ls_q.strobe_err;
  assign underrun_o = ls_q.underrun;
  assign bank_open_o = st_sync_q[10:3];
  assign suspended_o = st_sync_q[2];
  assign power_down_o = st_sync_q[1];
  assign self_refresh_o = st_sync_q[0];

  // activate sampled at a running edge opens that bank
  property p_act_opens;
    @(posedge ck_i) disable iff (link_rst)
    (live && cmd_code == `SCFE_CMD_ACT) |=> ls_q.bank_open[$past(cmd_i.ba)];
  endproperty
  a_act_opens: assert property (p_act_opens)
    else $error("activate did not open its bank");

  // strobe toggles at each crossing while data is driven
  property p_dqs_toggles;
    @(posedge ck_i) disable iff (link_rst)
    dq_oe_o |-> (dqs_o.rise && !dqs_o.fall && dqs_n_o.fall);
  endproperty
  a_dqs_toggles: assert property (p_dqs_toggles)
    else $error("strobe not toggling during read data");

  // a write beat taken with a wrong host strobe is flagged next edge
  property p_strobe_err;
    @(posedge ck_i) disable iff (link_rst)
    (run && ls_q.dir_wr && dqs_i != `SCFE_DQS_LEVELS &&
     ((ls_q.pend && ls_q.lat <= 6'h1) ||
      (ls_q.burst && ls_q.beat != ls_q.pairs))) |=> strobe_err_o;
  endproperty
  a_strobe_err: assert property (p_strobe_err)
    else $error("bad write strobe not flagged");

  // stopped clock holds output and burst address
  property p_freeze;
    @(posedge ck_i) disable iff (link_rst)
    !ls_q.cke_q |=> ($stable(dq_o) && $stable(ls_q.beat) &&
                     $stable(ls_q.lat) && $stable(ls_q.bank_open));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable was low");

  // self refresh is entered only with every bank idle
  property p_sref_idle;
    @(posedge ck_i) disable iff (link_rst)
    (ls_q.pm != PM_SELF_REFRESH) ##1 (ls_q.pm == PM_SELF_REFRESH)
      |-> (ls_q.bank_open == `SCFE_BANKS_IDLE);
  endproperty
  a_sref_idle: assert property (p_sref_idle)
    else $error("self refresh with an open bank");

  // single-bank precharge closes the addressed bank
  property p_pre_one;
    @(posedge ck_i) disable iff (link_rst)
    (live && cmd_code == `SCFE_CMD_PRE && !cmd_i.addr[`SCFE_ADDR_AP])
      |=> !ls_q.bank_open[$past(cmd_i.ba)];
  endproperty
  a_pre_one: assert property (p_pre_one)
    else $error("precharge left its bank open");

  // burst length is four or eight and the pair count stays in range
  property p_burst_len;
    @(posedge ck_i) disable iff (link_rst)
    ls_q.burst |-> ((ls_q.pairs == `SCFE_PAIRS_BL4 ||
                     ls_q.pairs == `SCFE_PAIRS_BL8) &&
                    ls_q.beat <= ls_q.pairs);
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("burst length out of range");

  // accepted read loads added latency plus cas latency
  property p_read_lat;
    @(posedge ck_i) disable iff (link_rst)
    (acc_rw && cmd_code == `SCFE_CMD_RD) |=> (ls_q.lat == $past(rl) &&
                                              ls_q.pend);
  endproperty
  a_read_lat: assert property (p_read_lat)
    else $error("read latency loaded wrongly");

  // deselected edge leaves banks and pending access untouched
  property p_cs_masks;
    @(posedge ck_i) disable iff (link_rst)
    (run && cmd_i.cke && cmd_i.cs_n && !ls_q.burst && !ls_q.pend)
      |=> ($stable(ls_q.bank_open) && !ls_q.pend);
  endproperty
  a_cs_masks: assert property (p_cs_masks)
    else $error("command taken with chip select high");

  // auto close shuts the bank when the burst ends
  property p_auto_close;
    @(posedge ck_i) disable iff (link_rst)
    (run && ls_q.burst && ls_q.beat == ls_q.pairs && ls_q.ap &&
     !(cmd_i.cke && cmd_code == `SCFE_CMD_ACT))
      |=> !ls_q.bank_open[$past(ls_q.ap_bank)];
  endproperty
  a_auto_close: assert property (p_auto_close)
    else $error("auto close left the bank open");
endmodule

// ### testbench/scfe_host_model.sv
`include "scfe_cfg.svh"
// behavioural host controller: link clock, commands and write bursts
module scfe_host_model (
  // link clock, made here
  output logic ck_o,
  // pins toward the device
  output scfe_pkg::scfe_cmd_t cmd_o,
  output scfe_pkg::scfe_pair_t dq_o,
  output scfe_pkg::scfe_dqs_t dqs_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import scfe_pkg::*;
  // free running clock, phase unrelated to the core clock
  initial begin
    ck_o = 1'h0;
    #7.3;
    forever #62.5 ck_o = ~ck_o;
  end
  // idle: deselected, clock enable low, strobe parked low
  initial begin
    cmd_o = {1'h0, 4'hF, 3'h0, 15'h0000};
    dq_o = 16'h5AA5;
    dqs_o = 2'h0;
  end
  // driven after the falling edge, steady at the rising crossing
  task automatic issue(input logic cke, input logic [3:0] code,
                       input logic [2:0] ba, input logic [14:0] addr);
    @(negedge ck_o);
    cmd_o = {cke, code, ba, addr};
    @(posedge ck_o);
    @(negedge ck_o);
    cmd_o.cs_n = 1'h1;
  endtask
  // caller is at a falling edge, so the next rising crossing sees it
  task automatic set_cke(input logic v);
    cmd_o.cke = v;
  endtask
  // pair p goes out before edge wl+p; bad spoils the strobe of pair 1
  task automatic write(input logic [2:0] ba, input logic [14:0] addr,
                       input int wl, input int n, input logic [63:0] d,
                       input logic bad);
    int p;
    issue(1'h1, `SCFE_CMD_WR, ba, addr);
    for (int e = 1; e < wl + n; e++) begin
      if (e >= wl) begin
        p = e - wl;
        dq_o = {d[16*p +: 8], d[16*p+8 +: 8]};
        dqs_o = (bad && p == 1) ? 2'h3 : 2'h2;
      end
      @(negedge ck_o);
    end
    // released lines must not look like a held copy of the last pair
    dq_o = ~dq_o;
    dqs_o = 2'h0;
  endtask
endmodule

// ### testbench/tb_top.sv
`include "scfe_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import scfe_pkg::*;
  localparam int CL = 11;
  localparam int CWL = 8;
  // core side
  logic clk_i, reset_i, bl4_i, interleave_i, fill_valid_i, fill_ready_o;
  logic [1:0] al_sel_i;
  logic [63:0] fill_data_i, wr_word_o;
  // link side
  logic ck, dq_oe_o, dqs_oe_o, wr_valid_o, strobe_err_o, underrun_o;
  logic suspended_o, power_down_o, self_refresh_o;
  logic [7:0] bank_open_o;
  scfe_cmd_t cmd;
  scfe_pair_t dq_in, dq_o;
  scfe_dqs_t dqs_in, dqs_o, dqs_n_o;
  // bookkeeping
  int mismatches, check_count;
  logic [31:0] seed;
  logic [63:0] exp_q[$];
  logic serr_seen, under_seen, susp_seen, pd_seen, sr_seen;

  scfe_front_end #(.CL(CL), .CWL(CWL), .DEPTH(16)) i_dut (
    .clk_i, .reset_i, .ck_i(ck), .cmd_i(cmd), .dq_i(dq_in),
    .dqs_i(dqs_in), .dq_o, .dq_oe_o, .dqs_o, .dqs_n_o, .dqs_oe_o,
    .bl4_i, .interleave_i, .al_sel_i, .fill_data_i, .fill_valid_i,
    .fill_ready_o, .wr_word_o, .wr_valid_o, .strobe_err_o, .underrun_o,
    .bank_open_o, .suspended_o, .power_down_o, .self_refresh_o);
  scfe_host_model i_host (.ck_o(ck), .cmd_o(cmd), .dq_o(dq_in),
    .dqs_o(dqs_in));

  // core clock
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  // short pulses are caught in their own domain and kept
  always @(posedge ck) begin
    if (strobe_err_o === 1'h1) serr_seen <= 1'h1;
    if (underrun_o === 1'h1) under_seen <= 1'h1;
  end
  always @(posedge clk_i) begin
    if (suspended_o === 1'h1) susp_seen <= 1'h1;
    if (power_down_o === 1'h1) pd_seen <= 1'h1;
    if (self_refresh_o === 1'h1) sr_seen <= 1'h1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // column of beat k in a burst starting at column c
  function automatic logic [2:0] col_of(input logic [2:0] c,
                                        input logic il, input logic [2:0] k);
    return il ? c ^ k : {c[2] ^ k[2], c[1:0] + k[1:0]};
  endfunction
  // read latency: added latency plus cas latency
  function automatic int rl_of(input logic [1:0] al);
    return (al == 2'h1 ? CL - 1 : al == 2'h2 ? CL - 2 : 0) + CL;
  endfunction

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // mode bits cross two flops, so give the link a few edges
  task automatic set_mode(input logic b4, input logic il,
                          input logic [1:0] al);
    @(negedge clk_i);
    bl4_i = b4;
    interleave_i = il;
    al_sel_i = al;
    repeat (4) @(posedge ck);
  endtask
  task automatic fill(input logic [63:0] w);
    @(negedge clk_i);
    fill_data_i = w;
    fill_valid_i = 1'h1;
    for (int t = 0; t < 40 && fill_ready_o !== 1'h1; t++) @(negedge clk_i);
    chk("fill ready", 64'h1, fill_ready_o);
    @(negedge clk_i);
    fill_valid_i = 1'h0;
    exp_q.push_back(w);
  endtask
  // read burst; susp drops clock enable for three edges, holding pair 1
  task automatic rd_chk(input logic [2:0] ba, input logic [2:0] c,
                        input logic susp);
    logic [63:0] w;
    logic [2:0] k;
    int n, p;
    w = exp_q.size() > 0 ? exp_q.pop_front() : 64'h0;
    n = bl4_i ? 2 : 4;
    i_host.issue(1'h1, `SCFE_CMD_RD, ba, {12'h000, c});
    repeat (rl_of(al_sel_i)) @(negedge ck);
    for (int j = 0; j < (susp ? n + 3 : n); j++) begin
      if (j > 0) @(negedge ck);
      p = !susp ? j : (j < 2 ? j : (j < 5 ? 1 : j - 3));
      k = 3'(2 * p);
      chk("read pair", {2'h3, 2'h2, 2'h1,
          w[8*col_of(c, interleave_i, k) +: 8],
          w[8*col_of(c, interleave_i, k + 3'h1) +: 8]},
          {dq_oe_o, dqs_oe_o, dqs_o, dqs_n_o, dq_o});
      if (susp && j == 0) i_host.set_cke(1'h0);
      if (susp && j == 3) i_host.set_cke(1'h1);
    end
    @(negedge ck);
    chk("read end oe", {4'h0, 2'h3},
        {dq_oe_o, dqs_oe_o, dqs_o, dqs_n_o});
  endtask
  // burst of eight write of random bytes, checked by column
  task automatic wr_chk(input logic [2:0] ba, input logic [2:0] c,
                        input logic ap, input logic bad);
    logic [63:0] d, e;
    seed = lfsr(seed);
    d[31:0] = seed;
    seed = lfsr(seed);
    d[63:32] = seed;
    for (int k = 0; k < 8; k++) e[8*col_of(c, interleave_i, 3'(k)) +: 8] =
        d[8*k +: 8];
    i_host.write(ba, {4'h0, ap, 7'h00, c}, rl_of(al_sel_i) - CL + CWL, 4, d,
                 bad);
    for (int t = 0; t < 4 && wr_valid_o !== 1'h1; t++) @(negedge ck);
    chk("write valid", 64'h1, wr_valid_o);
    if (!bad) chk("write word", e, wr_word_o);
  endtask

  initial begin
    reset_i = 1'h1;
    {bl4_i, interleave_i, al_sel_i, fill_valid_i} = 5'h00;
    fill_data_i = 64'h0;
    {serr_seen, under_seen, susp_seen, pd_seen, sr_seen} = 5'h00;
    mismatches = 0;
    check_count = 0;
    seed = 32'h56C9;
    // link reset needs several link clocks, so hold for 32 core cycles
    repeat (32) @(negedge clk_i);
    reset_i = 1'h0;
    repeat (4) @(posedge ck);
    chk("idle status", 64'h0,
        {bank_open_o, suspended_o, power_down_o, self_refresh_o});
    i_host.issue(1'h1, 4'hF, 3'h0, 15'h0000);
    // fill until the buffer refuses
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      fill({seed, ~seed});
    end
    chk("fifo full ready", 64'h0, fill_ready_o);
    i_host.issue(1'h1, `SCFE_CMD_ACT | 4'h8, 3'h5, 15'h0000);
    repeat (12) @(negedge clk_i);
    chk("bank flags", 64'h0, bank_open_o);
    i_host.issue(1'h1, `SCFE_CMD_ACT, 3'h5, 15'h0000);
    i_host.issue(1'h1, `SCFE_CMD_ACT, 3'h2, 15'h0000);
    repeat (12) @(negedge clk_i);
    chk("bank flags", 64'h24, bank_open_o);
    // drain with reads in random modes; selector code 3 acts as zero
    for (int i = 0; i < 15; i++) begin
      seed = lfsr(seed);
      set_mode(seed[0], seed[1], seed[3:2]);
      rd_chk(seed[4] ? 3'h5 : 3'h2, seed[7:5], 1'h0);
    end
    set_mode(1'h0, 1'h0, 2'h0);
    rd_chk(3'h5, 3'h3, 1'h1);
    chk("suspend flag", 64'h1, susp_seen);
    chk("no early underrun", 64'h0, under_seen);
    rd_chk(3'h2, 3'h6, 1'h0);
    chk("underrun", 64'h1, under_seen);
    wr_chk(3'h2, 3'h1, 1'h0, 1'h0);
    set_mode(1'h0, 1'h1, 2'h2);
    wr_chk(3'h2, 3'h6, 1'h0, 1'h0);
    chk("no strobe error", 64'h0, serr_seen);
    wr_chk(3'h2, 3'h0, 1'h0, 1'h1);
    chk("strobe error", 64'h1, serr_seen);
    wr_chk(3'h5, 3'h4, 1'h1, 1'h0);
    repeat (12) @(negedge clk_i);
    chk("bank flags", 64'h04, bank_open_o);
    // every bank closed before clock enable falls
    i_host.issue(1'h1, `SCFE_CMD_PRE, 3'h0, 15'h0400);
    i_host.issue(1'h1, `SCFE_CMD_REF, 3'h0, 15'h0000);
    i_host.issue(1'h0, 4'hF, 3'h0, 15'h0000);
    repeat (16) @(negedge clk_i);
    chk("power down", {8'h00, 1'h1}, {bank_open_o, pd_seen});
    i_host.issue(1'h1, 4'hF, 3'h0, 15'h0000);
    i_host.issue(1'h0, `SCFE_CMD_REF, 3'h0, 15'h0000);
    repeat (16) @(negedge clk_i);
    chk("self refresh", 64'h1, sr_seen);
    i_host.issue(1'h1, 4'hF, 3'h0, 15'h0000);
    end_sim();
  end
  // watchdog against a hung handshake
  initial begin
    #400us;
    mismatches++;
    end_sim();
  end
endmodule
